// File: hdl/timer16_pkg.sv
/*
 * Shared constants and types for the 16-bit timer counter with byte access.
 * Assumes a 32-bit APB register bus and registers that are one byte wide.
 */
package timer16_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CNT_LO  = 8'h00;
    localparam logic [7:0] OFS_CNT_HI  = 8'h04;
    localparam logic [7:0] OFS_CMPA_LO = 8'h08;
    localparam logic [7:0] OFS_CMPA_HI = 8'h0C;
    localparam logic [7:0] OFS_CMPB_LO = 8'h10;
    localparam logic [7:0] OFS_CMPB_HI = 8'h14;
    localparam logic [7:0] OFS_CAP_LO  = 8'h18;
    localparam logic [7:0] OFS_CAP_HI  = 8'h1C;
    localparam logic [7:0] OFS_CTRL_A  = 8'h20;
    localparam logic [7:0] OFS_CTRL_B  = 8'h24;
    localparam logic [7:0] OFS_FLAG    = 8'h28;

    // Field positions
    localparam int unsigned CS_LSB      = 0;
    localparam int unsigned WGM_A_LSB   = 0;
    localparam int unsigned WGM_B_LSB   = 3;
    localparam int unsigned FLAG_OVF    = 0;

    // Values after reset
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [7:0]  TEMP_RST = 8'h00;
    localparam logic [7:0]  CTRL_RST = 8'h00;

    // Sequence limits
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT   = 16'h00FF;
    localparam logic [15:0] TOP_9BIT   = 16'h01FF;
    localparam logic [15:0] TOP_10BIT  = 16'h03FF;

    // Prescaler divide chain counter width in bits
    localparam int unsigned PRE_DIV_W  = 10;

    // Clock source choices
    typedef enum logic [2:0] {
        CS_STOP     = 3'h0,
        CS_SYS      = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_e;

    // Counting sequence selector
    typedef logic [3:0] wgm_t;

    // Counter indications toward compare and waveform logic
    typedef struct packed {
        logic top_hit;
        logic bottom_hit;
        logic count_up;
        logic ovf_set;
    } timer_evt_s;

endpackage : timer16_pkg

// File: hdl/timer16_prescale.sv
/*
 * Free-running prescaler producing divided tick enables.
 * Assumes one system clock; outputs are one-cycle pulses.
 */
`timescale 1ns/100ps
module timer16_prescale
    import timer16_pkg::*;
#(
    parameter int unsigned DIV_W = PRE_DIV_W
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Divided enables
    output logic      tick_div8,
    output logic      tick_div64,
    output logic      tick_div256,
    output logic      tick_div1024
);

    logic [DIV_W-1:0] pre_ff;

    // Free-running divide chain
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // Terminal counts of each tap
    assign tick_div8    = &pre_ff[2:0];
    assign tick_div64   = &pre_ff[5:0];
    assign tick_div256  = &pre_ff[7:0];
    assign tick_div1024 = &pre_ff[DIV_W-1:0];

endmodule : timer16_prescale

// File: hdl/timer16_byte_access_counter.sv
/*
 * 16-bit timer counter with byte-wide register access through a shared
 * high-byte holding register, clock select, mode-driven sequence and
 * overflow flag. Assumes an APB master and a same-clock capture strobe;
 * the external count pin is asynchronous.
 */
`timescale 1ns/100ps
module timer16_byte_access_counter
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External count pin and capture trigger
    input  wire logic        ext_clk_pin,
    input  wire logic        capture_strobe,
    // Values and indications
    output logic      [15:0] count_value,
    output logic      [15:0] compare_value_a,
    output logic      [15:0] compare_value_b,
    output logic      [15:0] capture_value,
    output timer_evt_s       counter_evt,
    output logic             overflow_flag
);

    logic [15:0] cnt_ff, cmpa_ff, cmpb_ff, cap_ff;
    logic [15:0] nxt_cnt, nxt_cap;
    logic [7:0]  temp_ff, nxt_temp;
    logic [7:0]  ctrl_a_ff, ctrl_b_ff;
    logic        dir_up_ff, nxt_dir_up;
    logic        ovf_ff;
    logic        ext_s1_ff, ext_s2_ff, ext_s3_ff;

    // Access decode
    wire acc    = psel & penable;
    wire wr_acc = acc & pwrite;
    wire rd_acc = acc & ~pwrite;
    wire [7:0] wbyte = pwdata[7:0];

    wire hit_cnt_lo  = (paddr == OFS_CNT_LO);
    wire hit_cnt_hi  = (paddr == OFS_CNT_HI);
    wire hit_cmpa_lo = (paddr == OFS_CMPA_LO);
    wire hit_cmpa_hi = (paddr == OFS_CMPA_HI);
    wire hit_cmpb_lo = (paddr == OFS_CMPB_LO);
    wire hit_cmpb_hi = (paddr == OFS_CMPB_HI);
    wire hit_cap_lo  = (paddr == OFS_CAP_LO);
    wire hit_cap_hi  = (paddr == OFS_CAP_HI);
    wire hit_ctrl_a  = (paddr == OFS_CTRL_A);
    wire hit_ctrl_b  = (paddr == OFS_CTRL_B);
    wire hit_flag    = (paddr == OFS_FLAG);
    wire hit_hi      = hit_cnt_hi | hit_cmpa_hi | hit_cmpb_hi | hit_cap_hi;
    wire mapped      = hit_cnt_lo | hit_cmpa_lo | hit_cmpb_lo | hit_cap_lo |
                       hit_hi | hit_ctrl_a | hit_ctrl_b | hit_flag;

    // Zero-wait answer, error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    wire wgm_t wgm = {ctrl_b_ff[WGM_B_LSB +: 2], ctrl_a_ff[WGM_A_LSB +: 2]};
    wire [2:0] cs = ctrl_b_ff[CS_LSB +: 3];

    // Ceiling of the sequence per mode
    function automatic logic [15:0] top_of(input wgm_t m, input logic [15:0] a,
                                           input logic [15:0] c);
        logic [15:0] t;
        t = CNT_MAX;
        unique case (m)
            4'h1, 4'h5:        t = TOP_8BIT;
            4'h2, 4'h6:        t = TOP_9BIT;
            4'h3, 4'h7:        t = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: t = a;
            4'h8, 4'hA, 4'hC, 4'hE: t = c;
            default:           t = CNT_MAX;
        endcase
        return t;
    endfunction : top_of

    wire [15:0] top_val    = top_of(wgm, cmpa_ff, cap_ff);
    wire        icr_top    = (wgm == 4'h8) | (wgm == 4'hA) | (wgm == 4'hC) | (wgm == 4'hE);
    wire        dual_slope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
    wire        fast_pwm   = (wgm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});

    wire at_top    = (cnt_ff == top_val);
    wire at_bottom = (cnt_ff == CNT_BOTTOM);

    // External pin synchroniser and edge detect
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clk_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    wire ext_rise = ext_s2_ff & ~ext_s3_ff;
    wire ext_fall = ~ext_s2_ff & ext_s3_ff;
    logic d8, d64, d256, d1024;

    timer16_prescale #(
        .DIV_W        (PRE_DIV_W)
    ) u_prescale (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .tick_div8    (d8),
        .tick_div64   (d64),
        .tick_div256  (d256),
        .tick_div1024 (d1024)
    );

    // Tick source select, none when zero
    wire [7:0] tick_vec    = {ext_rise, ext_fall, d1024, d256, d64, d8, 1'b1, 1'b0};
    wire       timer_tick  = tick_vec[cs];

    wire [15:0] wr_word   = {temp_ff, wbyte};
    wire        cnt_lo_wr = wr_acc & hit_cnt_lo;
    wire        cap_lo_wr = wr_acc & hit_cap_lo;

    wire [15:0] cnt_inc = cnt_ff + 16'h0001;
    wire [15:0] cnt_dec = cnt_ff - 16'h0001;
    wire turn_down  = dual_slope & dir_up_ff & (cnt_ff >= top_val);
    wire turn_up    = dual_slope & ~dir_up_ff & at_bottom;
    wire step_up    = dual_slope ? (turn_up | (dir_up_ff & ~turn_down)) : 1'b1;
    wire clr_seq    = ~dual_slope & at_top;
    wire [15:0] step_val = clr_seq ? CNT_BOTTOM : (step_up ? cnt_inc : cnt_dec);
    wire count_op   = timer_tick & ~cnt_lo_wr;

    // Software write has priority over counting
    assign nxt_cnt    = cnt_lo_wr ? wr_word : (timer_tick ? step_val : cnt_ff);
    assign nxt_dir_up = ~dual_slope ? 1'b1 : (count_op ? step_up : dir_up_ff);

    wire ovf_point = dual_slope ? turn_up : (fast_pwm ? at_top : (cnt_ff == CNT_MAX));
    wire ovf_set   = count_op & ovf_point;
    wire ovf_clr   = wr_acc & hit_flag & pwdata[FLAG_OVF];

    assign nxt_temp = (wr_acc & hit_hi)     ? wbyte :
                      (rd_acc & hit_cnt_lo) ? cnt_ff[15:8] :
                      (rd_acc & hit_cap_lo) ? cap_ff[15:8] : temp_ff;

    // Capture write only when it sets the ceiling
    assign nxt_cap = (cap_lo_wr & icr_top) ? wr_word :
                     (capture_strobe & ~icr_top) ? cnt_ff : cap_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff    <= CNT_RST;
            temp_ff   <= TEMP_RST;
            cap_ff    <= CNT_RST;
            dir_up_ff <= 1'b1;
        end else begin
            cnt_ff    <= nxt_cnt;
            temp_ff   <= nxt_temp;
            cap_ff    <= nxt_cap;
            dir_up_ff <= nxt_dir_up;
        end
    end

    // Compare and control registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmpa_ff   <= CNT_RST;
            cmpb_ff   <= CNT_RST;
            ctrl_a_ff <= CTRL_RST;
            ctrl_b_ff <= CTRL_RST;
        end else begin
            if (wr_acc & hit_cmpa_lo) cmpa_ff   <= wr_word;
            if (wr_acc & hit_cmpb_lo) cmpb_ff   <= wr_word;
            if (wr_acc & hit_ctrl_a)  ctrl_a_ff <= wbyte;
            if (wr_acc & hit_ctrl_b)  ctrl_b_ff <= wbyte;
        end
    end

    // Sticky overflow flag, set beats clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= ovf_set | (ovf_ff & ~ovf_clr);
        end
    end

    wire [7:0] rd_byte = hit_cnt_lo  ? cnt_ff[7:0]   :
                         hit_cmpa_lo ? cmpa_ff[7:0]  :
                         hit_cmpa_hi ? cmpa_ff[15:8] :
                         hit_cmpb_lo ? cmpb_ff[7:0]  :
                         hit_cmpb_hi ? cmpb_ff[15:8] :
                         hit_cap_lo  ? cap_ff[7:0]   :
                         (hit_cnt_hi | hit_cap_hi) ? temp_ff :
                         hit_ctrl_a  ? ctrl_a_ff     :
                         hit_ctrl_b  ? ctrl_b_ff     :
                         hit_flag    ? {7'h00, ovf_ff} : 8'h00;

    assign prdata = {24'h000000, rd_byte};

    // Outputs
    assign count_value            = cnt_ff;
    assign compare_value_a        = cmpa_ff;
    assign compare_value_b        = cmpb_ff;
    assign capture_value          = cap_ff;
    assign overflow_flag          = ovf_ff;
    assign counter_evt.top_hit    = at_top;
    assign counter_evt.bottom_hit = at_bottom;
    assign counter_evt.count_up   = dir_up_ff;
    assign counter_evt.ovf_set    = ovf_set;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_low_write_load: assert property (cnt_lo_wr |=> cnt_ff == $past(wr_word))
        else $error("counter low write did not load word");

    a_read_copy_hold: assert property (rd_acc & hit_cnt_lo |=> temp_ff == $past(cnt_ff[15:8]))
        else $error("low read did not copy high byte");

    a_cmp_hi_direct: assert property (rd_acc & hit_cmpa_hi
        |-> prdata[7:0] == cmpa_ff[15:8] ##1 temp_ff == $past(temp_ff))
        else $error("compare high read misbehaved");

    a_cnt_hi_hold: assert property (rd_acc & hit_cnt_hi |-> prdata[7:0] == temp_ff)
        else $error("counter high read not from holding register");

    a_hold_keeps: assert property (wr_acc & (hit_cnt_lo | hit_cmpa_lo | hit_cmpb_lo)
        |=> $stable(temp_ff))
        else $error("holding register changed on low write");

    a_stop_holds: assert property ((cs == CS_STOP) & ~cnt_lo_wr |=> $stable(cnt_ff))
        else $error("counter moved while stopped");

    a_step_single: assert property (count_op & ~dual_slope & ~at_top
        |=> cnt_ff == 16'($past(cnt_ff) + 16'h0001))
        else $error("single slope step not one");

    a_write_wins: assert property (cnt_lo_wr & timer_tick
        |=> cnt_ff == {$past(temp_ff), $past(wbyte)})
        else $error("count overrode software write");

    a_cap_guard: assert property (cap_lo_wr & ~icr_top & ~capture_strobe |=> $stable(cap_ff))
        else $error("capture written outside ceiling mode");

    a_ovf_sticky: assert property (ovf_set |=> overflow_flag)
        else $error("overflow flag not set");

    c_cnt_write:  cover property (cnt_lo_wr ##1 rd_acc & hit_cnt_lo);
    c_ovf_clear:  cover property (overflow_flag ##1 ovf_clr);
    c_dual_turn:  cover property (count_op & turn_down);
    c_cap_write:  cover property (cap_lo_wr & icr_top);

endmodule : timer16_byte_access_counter

// File: testbench/cpu_bus.sv
/*
 * CPU-side APB master model doing byte and two-byte timer accesses.
 * Assumes an APB slave on the same clock; waits for pready each time.
 */
`timescale 1ns/100ps
module cpu_bus (
    // Clock
    input  wire logic        clk_sys,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic last_err;

    // Idle bus from time zero
    initial begin
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        last_err = 1'b0;
    end

    // One transfer, request held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q        = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~{24'h00_0000, d};
    endtask : xfer

    // Single byte write and read
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr8

    task automatic rd8(input logic [7:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask : rd8

    // no other access between the two bytes
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr8(lo + 8'h04, v[15:8]);
        wr8(lo, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        logic [7:0] l;
        logic [7:0] h;
        rd8(lo, l);
        rd8(lo + 8'h04, h);
        v = {h, l};
    endtask : rd16
endmodule : cpu_bus

// File: testbench/timer16_byte_access_counter_tb.sv
/*
 * Self-checking bench for the byte-access timer counter.
 * Assumes the cpu_bus model as APB master and a 100 MHz clock.
 */
`timescale 1ns/100ps
module timer16_byte_access_counter_tb
    import timer16_pkg::*;
;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        ext_clk_pin, capture_strobe, overflow_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] count_value, compare_value_a, compare_value_b, capture_value;
    timer_evt_s  counter_evt;
    int          fail_count, checks_done;

    timer16_byte_access_counter i_timer16_byte_access_counter (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .capture_strobe(capture_strobe), .count_value(count_value), .compare_value_a(compare_value_a),
        .compare_value_b(compare_value_b), .capture_value(capture_value), .counter_evt(counter_evt),
        .overflow_flag(overflow_flag));

    cpu_bus i_cpu_bus (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Reset state
    task automatic t_reset();
        logic [7:0] q;
        check("count", count_value, CNT_RST);
        check("flag", 16'(overflow_flag), 16'h0000);
        check("count_up", 16'(counter_evt.count_up), 16'h0001);
        check("ovf_pulse", 16'(counter_evt.ovf_set), 16'h0000);
        i_cpu_bus.rd8(OFS_CTRL_B, q);
        check("ctrl_b", 16'(q), 16'(CTRL_RST));
        i_cpu_bus.rd8(OFS_CNT_HI, q);
        check("holding", 16'(q), 16'(TEMP_RST));
    endtask : t_reset

    // Word access and shared holding byte
    task automatic t_words();
        logic [15:0] v;
        logic [7:0]  q;
        i_cpu_bus.wr16(OFS_CNT_LO, 16'h01FF);
        #1;
        check("cnt_wr", count_value, 16'h01FF);
        i_cpu_bus.rd16(OFS_CNT_LO, v);
        check("cnt_rd", v, 16'h01FF);
        i_cpu_bus.wr8(OFS_CNT_HI, 8'h12);
        #1;
        check("cnt_hi_wr", count_value, 16'h01FF);
        i_cpu_bus.rd8(OFS_CNT_HI, q);
        check("cnt_hi_rd", 16'(q), 16'h0012);
        i_cpu_bus.wr8(OFS_CMPA_LO, 8'h34);
        i_cpu_bus.wr8(OFS_CMPB_LO, 8'h56);
        #1;
        check("cmp_a", compare_value_a, 16'h1234);
        check("cmp_b", compare_value_b, 16'h1256);
        i_cpu_bus.rd8(OFS_CNT_LO, q);
        i_cpu_bus.rd8(OFS_CMPB_HI, q);
        check("cmp_b_hi", 16'(q), 16'h0012);
        i_cpu_bus.rd8(OFS_CNT_HI, q);
        check("hold_kept", 16'(q), 16'h0001);
    endtask : t_words

    // Ticking, write priority, stop
    task automatic t_ticks();
        logic [15:0] a;
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_SYS));
        @(posedge clk_sys);
        #1;
        a = count_value;
        @(posedge clk_sys);
        #1;
        check("step", count_value, a + 16'h0001);
        i_cpu_bus.wr16(OFS_CNT_LO, 16'h0100);
        #1;
        check("wr_wins", count_value, 16'h0100);
        @(posedge clk_sys);
        #1;
        check("next_tick", count_value, 16'h0101);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_STOP));
        repeat (2) @(posedge clk_sys);
        #1;
        a = count_value;
        repeat (5) @(posedge clk_sys);
        #1;
        check("stopped", count_value, a);
    endtask : t_ticks

    // External rising edges as tick source
    task automatic t_ext_pin();
        i_cpu_bus.wr16(OFS_CNT_LO, 16'h0000);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_EXT_RISE));
        repeat (3) begin
            repeat (4) @(posedge clk_sys);
            ext_clk_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_clk_pin <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        #1;
        check("ext_count", count_value, 16'h0003);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_STOP));
    endtask : t_ext_pin

    // Ceiling per mode 4..7 and floor
    task automatic t_ceiling();
        logic [15:0] top [4] = '{16'h1234, TOP_8BIT, TOP_9BIT, TOP_10BIT};
        i_cpu_bus.wr8(OFS_CTRL_B, 8'h08);
        for (int m = 0; m < 4; m++) begin
            i_cpu_bus.wr8(OFS_CTRL_A, 8'(m));
            i_cpu_bus.wr16(OFS_CNT_LO, top[m]);
            #1;
            check("top", 16'(counter_evt.top_hit), 16'h0001);
            i_cpu_bus.wr16(OFS_CNT_LO, top[m] - 16'h0001);
            #1;
            check("below_top", 16'(counter_evt.top_hit), 16'h0000);
        end
        i_cpu_bus.wr16(OFS_CNT_LO, CNT_BOTTOM);
        #1;
        check("bottom", 16'(counter_evt.bottom_hit), 16'h0001);
        i_cpu_bus.wr8(OFS_CTRL_A, 8'h00);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'h00);
    endtask : t_ceiling

    // Wrap past the maximum sets the flag
    task automatic t_overflow();
        int n;
        i_cpu_bus.wr16(OFS_CNT_LO, 16'hFFFD);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_SYS));
        #1;
        check("ovf_early", 16'(overflow_flag), 16'h0000);
        n = 0;
        while (overflow_flag !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("ovf_set", 16'(overflow_flag), 16'h0001);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'(CS_STOP));
        i_cpu_bus.wr8(OFS_FLAG, 8'h01);
        #1;
        check("ovf_clr", 16'(overflow_flag), 16'h0000);
    endtask : t_overflow

    // Capture write gating and unmapped place
    task automatic t_capture();
        logic [15:0] v;
        logic [7:0]  q;
        i_cpu_bus.wr16(OFS_CAP_LO, 16'h2233);
        #1;
        check("cap_locked", capture_value, 16'h0000);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'h18);
        i_cpu_bus.wr16(OFS_CAP_LO, 16'h2233);
        i_cpu_bus.rd16(OFS_CAP_LO, v);
        check("cap_open", v, 16'h2233);
        i_cpu_bus.wr8(OFS_CTRL_B, 8'h00);
        i_cpu_bus.wr16(OFS_CNT_LO, 16'h4567);
        @(posedge clk_sys);
        capture_strobe <= 1'b1;
        @(posedge clk_sys);
        capture_strobe <= 1'b0;
        #1;
        check("cap_strobe", capture_value, 16'h4567);
        i_cpu_bus.rd8(8'h2C, q);
        check("slverr", 16'(i_cpu_bus.last_err), 16'h0001);
    endtask : t_capture

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        sys_rst        = 1'b1;
        ext_clk_pin    = 1'b0;
        capture_strobe = 1'b0;
        fail_count     = 0;
        checks_done    = 0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_words();
        t_ticks();
        t_ext_pin();
        t_ceiling();
        t_overflow();
        t_capture();
        wrap_up();
    end
endmodule : timer16_byte_access_counter_tb
